// >>> dv/chipset_model.sv
/* Chipset and second bus agent facing the sideband pins.
   Assumes the bench changes its request levels just after an edge. */
`timescale 1ns/1ps
`default_nettype none
module chipset_model (
   input  wire logic       init_req,
   input  wire logic [1:0] irq_req,
   input  wire logic       stop_req,
   input  wire logic       probe_req,
   input  wire logic       hot_req,
   input  wire logic       prio_req,
   input  wire logic       thermal_alarm_n_out,
   input  wire logic       thermal_alarm_n_oe,
   input  wire logic       lock_n_out,
   input  wire logic       lock_n_oe,
   output logic            init_n,
   output logic      [1:0] local_irq_n,
   output logic            stop_clock_request_n,
   output logic            probe_request_n,
   output logic            thermal_alarm_n_in,
   output logic            bus_taken
);
   logic lock_pin;  // Lock wire, pulled up when released
   // init held as long as the bench asks
   assign init_n = !init_req;
   // interrupt and probe pins, active low
   assign local_irq_n = ~irq_req;
   assign probe_request_n = !probe_req;
   assign stop_clock_request_n = !stop_req;
   // open drain: either party pulls low, else pull-up
   assign thermal_alarm_n_in =
      !((thermal_alarm_n_oe && !thermal_alarm_n_out) || hot_req);
   // priority agent takes the bus only with the lock released
   assign lock_pin = !(lock_n_oe && !lock_n_out);
   assign bus_taken = prio_req && lock_pin;
endmodule
`default_nettype wire

// >>> dv/sideband_checker.sv
/* Checker for sideband_ctrl pin timing, bound to the design.
   Assumes clk_en stays high and the control bits keep reset values. */
`timescale 1ns/1ps
`default_nettype none
module sideband_checker (
   input wire logic       core_clk,
   input wire logic       sys_rst,
   input wire logic       init_n,
   input wire logic [1:0] local_irq_n,
   input wire logic       stop_clock_request_n,
   input wire logic       probe_request_n,
   input wire logic       thermal_alarm_n_in,
   input wire logic       thermal_alarm_n_out,
   input wire logic       thermal_alarm_n_oe,
   input wire logic       probe_ready_n,
   input wire logic       fp_error_break_event_n,
   input wire logic       lock_n_out,
   input wire logic       lock_n_oe,
   input wire logic       temp_over_limit,
   input wire logic       lock_seq_end,
   input wire logic       core_debug_ready,
   input wire logic       int_regs_reset,
   input wire logic       run_self_test,
   input wire logic       nonmaskable_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Lock window still open, and the cycle that closes it
   sequence lock_open;
      !lock_n_out && !lock_seq_end;
   endsequence
   sequence lock_close;
      !lock_n_out && lock_seq_end;
   endsequence
   init_pulse_a: assert property ($fell(init_n) |-> ##[2:4] int_regs_reset)
      else $error("init fall gave no register reset");
   self_test_a: assert property (run_self_test |-> $past(sys_rst, 2))
      else $error("self test away from reset release");
   nmi_pin_a: assert property ($rose(nonmaskable_irq) |-> !$past(local_irq_n[1], 3))
      else $error("non-maskable pulse without its pin");
   lock_hold_a: assert property (lock_open |=> !lock_n_out)
      else $error("lock dropped inside the window");
   lock_end_a: assert property (lock_close |=> lock_n_out)
      else $error("lock not released after the last transfer");
   // Two reset edges are enough for every bus output to let go
   reset_quiet_a: assert property (disable iff (1'b0) sys_rst [*2] |->
      !lock_n_oe && !thermal_alarm_n_oe && probe_ready_n && fp_error_break_event_n)
      else $error("output still driven in reset");
   hot_drive_a: assert property (temp_over_limit |=> thermal_alarm_n_oe && !thermal_alarm_n_out)
      else $error("alarm not driven when hot");
   probe_ready_a: assert property ((!probe_request_n && core_debug_ready) [*4] |->
      !probe_ready_n)
      else $error("probe ready missing");
   break_event_a: assert property ((!probe_request_n && !stop_clock_request_n) [*4] |->
      !fp_error_break_event_n)
      else $error("break event missing");
endmodule
bind sideband_ctrl sideband_checker i_chk (.*);
`default_nettype wire

// >>> dv/sideband_ctrl_test.sv
/* Bench for sideband_ctrl: AHB-Lite tasks and one task per scenario.
   Assumes the chipset model and the bound checker beside the design. */
`timescale 1ns/1ps
`default_nettype none
`include "sideband_params.svh"
module sideband_ctrl_test;
   logic        core_clk = 0, sys_rst = 1, clk_en = 1, fp_error = 0;
   logic        hsel = 0, hwrite = 0, clr = 1, init_req = 1;
   logic [7:0]  haddr = 0;
   logic [1:0]  htrans = 0, irq_req = 0, local_irq_n, local_int;
   logic [2:0]  hsize = 3'h2;  // Whole words only
   logic [31:0] hwdata = 0, hrdata, fetch_addr;
   logic        stop_req = 0, probe_req = 0, hot_req = 0, prio_req = 0;
   logic        temp_over_limit = 0, lock_seq_start = 0, lock_seq_end = 0;
   logic        snoop_req = 0, core_debug_ready = 0, hready, hreadyout, hresp;
   logic        irq, init_n, stop_clock_request_n, probe_request_n, bus_taken;
   logic        thermal_alarm_n_in, thermal_alarm_n_out, thermal_alarm_n_oe;
   logic        probe_ready_n, fp_error_break_event_n, lock_n_out, lock_n_oe;
   logic        int_regs_reset, run_self_test, fetch_restart, snoop_ack;
   logic        maskable_irq, nonmaskable_irq, thermal_throttle, debug_mode_req;
   logic [3:0]  seen;  // Sticky copy of one-cycle pulses
   int          failures = 0, check_count = 0;
   assign hready = hreadyout;  // Lone slave drives the bus ready
   always #20 core_clk = !core_clk;
   // Pulses last one cycle, so latch them for later judging
   always @(posedge core_clk)
      seen <= clr ? 4'h0 : seen | {nonmaskable_irq, run_self_test, fetch_restart, int_regs_reset};
   sideband_ctrl i_dut (.*);
   chipset_model i_chipset (.*);
   task automatic check(input string name, input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Let n edges pass, then look once outputs have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #5;
   endtask
   // Wait for ready at an edge; bounded so a hung slave ends the run
   task automatic hold;
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hready !== 1'b1 && n < 16);
      if (hready !== 1'b1) begin
         failures++;
         report_and_stop;
      end
   endtask
   // Single transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hold;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hold;
      r = hrdata;
   endtask
   task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      check(name, r, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   // Init held through reset, reset values, unmapped place
   task automatic test_boot;
      cyc(4);
      check("lock_oe", lock_n_oe, 1'b0);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      clr <= 1'b0;
      cyc(3);
      check("self_test", seen[2], 1'b1);
      @(posedge core_clk);
      init_req <= 1'b0;
      rd("ctrl", `SB_OFF_CTRL, `SB_CTRL_RST);
      rd("mask", `SB_OFF_IRQ_MASK, 32'h0);
      wr(8'h14, 32'hFFFF_FFFF);
      rd("unmapped", 8'h14, 32'h0);
   endtask
   // Soft init with a snoop in flight, its interrupt, mask and clear
   task automatic test_init;
      wr(`SB_OFF_IRQ_STAT, 32'h3F);
      wr(`SB_OFF_IRQ_MASK, 32'h1);
      @(posedge core_clk);
      clr <= 1'b1;
      init_req <= 1'b1;
      snoop_req <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      cyc(5);
      check("restart", seen[1:0], 2'h3);
      check("vector", fetch_addr, `SB_RESET_VECTOR);
      check("snoop", snoop_ack, 1'b1);
      check("irq", irq, 1'b1);
      @(posedge core_clk);
      init_req <= 1'b0;
      snoop_req <= 1'b0;
      wr(`SB_OFF_IRQ_MASK, 32'h0);
      cyc(2);
      check("irq_mask", irq, 1'b0);
      wr(`SB_OFF_IRQ_STAT, 32'h1);
      rd("stat", `SB_OFF_IRQ_STAT, 32'h0);
   endtask
   // Local pins as controller lines, then maskable and non-maskable
   task automatic test_lint;
      @(posedge core_clk);
      irq_req <= 2'h1;
      cyc(5);
      check("one_line", local_int, 2'h1);
      check("mirq_off", maskable_irq, 1'b0);
      wr(`SB_OFF_CTRL, 32'h2);
      cyc(2);
      check("mirq_on", maskable_irq, 1'b1);
      @(posedge core_clk);
      irq_req <= 2'h2;
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      cyc(5);
      check("nmi", seen[3], 1'b1);
      check("mirq_gone", maskable_irq, 1'b0);
      @(posedge core_clk);
      irq_req <= 2'h0;
      wr(`SB_OFF_CTRL, `SB_CTRL_RST);
   endtask
   // Locked window keeps the priority agent off until it closes
   task automatic test_lock;
      @(posedge core_clk);
      lock_seq_start <= 1'b1;
      prio_req <= 1'b1;
      @(posedge core_clk);
      lock_seq_start <= 1'b0;
      cyc(4);
      check("lock_low", lock_n_out, 1'b0);
      check("agent_wait", bus_taken, 1'b0);
      rd("lock_reg", `SB_OFF_LOCK, 32'h1);
      @(posedge core_clk);
      lock_seq_end <= 1'b1;
      @(posedge core_clk);
      lock_seq_end <= 1'b0;
      cyc(2);
      check("agent_go", bus_taken, 1'b1);
   endtask
   // Own sensor, then system alarm, then probe with stop-clock
   task automatic test_pins;
      @(posedge core_clk);
      temp_over_limit <= 1'b1;
      cyc(5);
      check("alarm", thermal_alarm_n_in, 1'b0);
      @(posedge core_clk);
      temp_over_limit <= 1'b0;
      hot_req <= 1'b1;
      cyc(5);
      check("ext_hot", {thermal_alarm_n_oe, thermal_throttle}, 2'h1);
      @(posedge core_clk);
      hot_req <= 1'b0;
      probe_req <= 1'b1;
      core_debug_ready <= 1'b1;
      cyc(5);
      check("cool", thermal_throttle, 1'b0);
      check("probe", {probe_ready_n, debug_mode_req}, 2'h1);
      @(posedge core_clk);
      fp_error <= 1'b1;
      cyc(2);
      check("fp_error", fp_error_break_event_n, 1'b0);
      @(posedge core_clk);
      fp_error <= 1'b0;
      cyc(2);
      check("fp_clear", fp_error_break_event_n, 1'b1);
      @(posedge core_clk);
      stop_req <= 1'b1;
      cyc(5);
      check("break", fp_error_break_event_n, 1'b0);
      rd("status", `SB_OFF_STATUS, (32'h1 << `SB_ST_PROBE) | (32'h1 << `SB_ST_BREAK));
   endtask
   initial begin
      test_boot;
      test_init;
      test_lint;
      test_lock;
      test_pins;
      report_and_stop;
   end
endmodule
`default_nettype wire

// >>> verilog/sideband_ctrl.sv
/*
 * Processor sideband control: soft init with self-test strap, local
 * interrupt pins with fallback to maskable/non-maskable, atomic lock,
 * two-way thermal alarm, debug probe pins, AHB-Lite register slave.
 * Assumes one 25 MHz core_clk, synchronous active-high reset, and that
 * the core pulses lock_seq_start/lock_seq_end around locked sequences.
 */
// Decided for this implementation: the address map and register access over AHB-Lite.
// Operation
// - Soft init resets integer state, keeps caches
// - Fetch resumes at configured reset vector
// - Snoops still serviced during soft init
// - Soft init accepted asynchronously
// - Init high at reset release runs self-test
// - Controller off: pin0 maskable, pin1 non-maskable
// - Local interrupt pins accepted asynchronously
// - Interrupt controller enabled by default after reset
// - Lock held from first to last transaction
// - Drive thermal alarm when sensor hot
// - External alarm throttles until released
// - Probe request answered on probe ready
// - Probe request during stop-clock raises break event
// - Bus outputs dropped within two clocks of reset
`timescale 1ns/1ps
`default_nettype none
`include "sideband_params.svh"
module sideband_ctrl (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   // Pins
   input  wire logic        init_n,
   input  wire logic [1:0]  local_irq_n,
   input  wire logic        stop_clock_request_n,
   input  wire logic        probe_request_n,
   input  wire logic        thermal_alarm_n_in,
   output logic             thermal_alarm_n_out,
   output logic             thermal_alarm_n_oe,
   output logic             probe_ready_n,
   output logic             fp_error_break_event_n,
   output logic             lock_n_out,
   output logic             lock_n_oe,
   // Core side
   input  wire logic        temp_over_limit,
   input  wire logic        fp_error,
   input  wire logic        lock_seq_start,
   input  wire logic        lock_seq_end,
   input  wire logic        snoop_req,
   input  wire logic        core_debug_ready,
   output logic             int_regs_reset,
   output logic             run_self_test,
   output logic      [31:0] fetch_addr,
   output logic             fetch_restart,
   output logic             snoop_ack,
   output logic             maskable_irq,
   output logic             nonmaskable_irq,
   output logic      [1:0]  local_int,
   output logic             thermal_throttle,
   output logic             debug_mode_req
);
   import sideband_pkg::*;

   logic [31:0] ctrl_q;          // Software control bits
   logic [`SB_EV_W-1:0] ist_q;   // Sticky interrupt status
   logic [`SB_EV_W-1:0] imask_q; // Interrupt enables
   logic [4:0]  pin_s;           // Synchronised pin levels, active high
   logic        init_s, stop_s, probe_s, hot_s;
   logic [1:0]  lirq_s;
   logic        init_d1_q;       // Previous init level for edge detect
   logic        rst_d1_q;        // Reset seen last cycle
   logic        nmi_d1_q;        // Previous fallback NMI level
   logic        hot_in_d1_q;
   logic        probe_d1_q;
   logic [1:0]  oe_hist_q;       // Own alarm drive over the last two edges
   logic        lic_en;
   logic        ext_hot;
   logic        brk_pend_q;      // Pending break event latch
   lock_state_t lock_st_q;       // Lock sequencer
   logic        ph_v_q;          // Data phase pending
   logic        ph_w_q;
   logic [7:0]  ph_a_q;
   logic [31:0] status_w;
   logic [`SB_EV_W-1:0] ev;

   // Pin synchroniser keeps sampling through reset, so the init strap is
   // already settled at the first edge after release
   // two-stage synchroniser
   sync2 #(.W(5)) u_sync (
      .core_clk (core_clk),
      .clk_en   (clk_en),
      .async_in ({~init_n, ~local_irq_n, ~stop_clock_request_n,
                  ~probe_request_n}),
      .sync_out (pin_s)
   );
   // Thermal pin is shared, so its input is synchronised on its own
   logic hot_m_q;
   logic hot_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         hot_m_q <= 1'b0;
         hot_q   <= 1'b0;
      end else if (clk_en) begin
         hot_m_q <= ~thermal_alarm_n_in;
         hot_q   <= hot_m_q;
      end
   end

   assign init_s = pin_s[4];
   assign lirq_s  = pin_s[3:2];
   assign stop_s  = pin_s[1];
   assign probe_s = pin_s[0];
   assign hot_s  = hot_q;
   assign lic_en = ctrl_q[`SB_CTRL_LIC_EN];
   // Pin low while we drive it ourselves is our own alarm, not the system's;
   // the synchronised level lags two edges, so recent own drive masks it too
   assign ext_hot = hot_s & ~thermal_alarm_n_oe & ~|oe_hist_q;

   // Edge trackers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         init_d1_q   <= 1'b0;
         nmi_d1_q    <= 1'b0;
         hot_in_d1_q <= 1'b0;
         probe_d1_q  <= 1'b0;
         oe_hist_q   <= 2'b00;
      end else if (clk_en) begin
         init_d1_q   <= init_s;
         nmi_d1_q    <= lirq_s[1];
         hot_in_d1_q <= ext_hot;
         probe_d1_q  <= probe_s;
         // Shift in our own drive enable to cover the synchroniser delay
         oe_hist_q   <= {oe_hist_q[0], thermal_alarm_n_oe};
      end
   end

   // Reset-release tracker runs even through reset to see the falling edge
   always_ff @(posedge core_clk) begin
      if (clk_en) begin
         rst_d1_q <= sys_rst;
      end
   end

   // Soft init and self-test strap
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         int_regs_reset <= 1'b0;
         run_self_test  <= 1'b0;
         fetch_restart  <= 1'b0;
         fetch_addr     <= `SB_RESET_VECTOR;
      end else if (clk_en) begin
         // integer-only reset
         // Caches and FP state have no reset here, they live in the core
         int_regs_reset <= init_s & ~init_d1_q;
         // strap at release
         // Synchronised init is already valid on the first edge after release
         run_self_test  <= rst_d1_q & init_s;
         fetch_restart  <= init_s & ~init_d1_q;
         fetch_addr     <= `SB_RESET_VECTOR;
      end
   end

   // snoops continue in init
   // Snoop acknowledge ignores init entirely
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         snoop_ack <= 1'b0;
      end else if (clk_en) begin
         snoop_ack <= snoop_req;
      end
   end

   // Local interrupt routing
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         maskable_irq    <= 1'b0;
         nonmaskable_irq <= 1'b0;
         local_int       <= 2'b00;
      end else if (clk_en) begin
         maskable_irq    <= ~lic_en & lirq_s[0];
         // Non-maskable is edge sensitive, one pulse per rising level
         nonmaskable_irq <= ~lic_en & lirq_s[1] & ~nmi_d1_q;
         local_int       <= lic_en ? lirq_s : 2'b00;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         lock_st_q <= LK_IDLE;
      end else if (clk_en) begin
         unique case (lock_st_q)
            LK_IDLE: if (lock_seq_start) lock_st_q <= LK_HOLD;
            LK_HOLD: if (lock_seq_end)   lock_st_q <= LK_DONE;
            LK_DONE: lock_st_q <= LK_IDLE;
            // Unused code falls back to idle
            default: lock_st_q <= LK_IDLE;
         endcase
      end
   end

   // lock visible to priority agent
   // Lock asserts the cycle after start and stays through the end pulse
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         lock_n_out <= 1'b1;
         lock_n_oe  <= 1'b0;
      end else if (clk_en) begin
         lock_n_out <= ~((lock_st_q == LK_IDLE && lock_seq_start) ||
                         (lock_st_q == LK_HOLD && !lock_seq_end));
         lock_n_oe  <= 1'b1;
      end
   end

   // Thermal alarm and throttle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         thermal_alarm_n_out <= 1'b1;
         thermal_alarm_n_oe  <= 1'b0;
         thermal_throttle    <= 1'b0;
      end else if (clk_en) begin
         thermal_alarm_n_out <= ~(temp_over_limit | ctrl_q[`SB_CTRL_HOT]);
         thermal_alarm_n_oe  <= temp_over_limit | ctrl_q[`SB_CTRL_HOT];
         // external alarm throttles
         // Throttle follows either source and stops when both release
         thermal_throttle    <= ctrl_q[`SB_CTRL_TT_EN] &
                                (temp_over_limit | ctrl_q[`SB_CTRL_HOT] | ext_hot);
      end
   end

   // Debug probe and break event
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         probe_ready_n          <= 1'b1;
         debug_mode_req         <= 1'b0;
         brk_pend_q             <= 1'b0;
         fp_error_break_event_n <= 1'b1;
      end else if (clk_en) begin
         debug_mode_req <= probe_s;
         probe_ready_n  <= ~(probe_s & (core_debug_ready | ctrl_q[`SB_CTRL_PROBE_RDY]));
         // break event latch
         // Held until stop-clock drops, set wins over release
         if (stop_s && probe_s) begin
            brk_pend_q <= 1'b1;
         end else if (!stop_s) begin
            brk_pend_q <= 1'b0;
         end
         fp_error_break_event_n <= ~(stop_s ? (brk_pend_q | probe_s) : fp_error);
      end
   end

   // Events for the interrupt status
   // Local line activity and the maskable line are levels, the others are rising edges
   assign ev = {lic_en & |lirq_s,
                probe_s & ~probe_d1_q,
                ext_hot & ~hot_in_d1_q,
                ~lic_en & lirq_s[0],
                ~lic_en & lirq_s[1] & ~nmi_d1_q,
                init_s & ~init_d1_q};

   // Twelve live bits, upper twenty read as zero
   assign status_w = {20'h00000, snoop_ack, ~fp_error_break_event_n,
                      ~lock_n_out, run_self_test, probe_s, ext_hot,
                      thermal_throttle, local_int, nonmaskable_irq,
                      maskable_irq, init_s};

   // AHB-Lite address phase capture; zero wait states, always OKAY
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ph_v_q <= 1'b0;
         ph_w_q <= 1'b0;
         ph_a_q <= 8'h00;
      end else if (clk_en && hready) begin
         ph_v_q <= hsel & htrans[1];
         ph_w_q <= hwrite;
         ph_a_q <= haddr;
      end
   end

   // Control and mask registers written in the data phase
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_q  <= `SB_CTRL_RST;
         imask_q <= '0;
      end else if (clk_en && ph_v_q && ph_w_q) begin
         if (ph_a_q == `SB_OFF_CTRL) ctrl_q <= {28'h0000000, hwdata[3:0]};
         if (ph_a_q == `SB_OFF_IRQ_MASK) imask_q <= hwdata[`SB_EV_W-1:0];
      end
   end

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ist_q <= '0;
      end else if (clk_en) begin
         if (ph_v_q && ph_w_q && ph_a_q == `SB_OFF_IRQ_STAT) begin
            ist_q <= (ist_q & ~hwdata[`SB_EV_W-1:0]) | ev;
         end else begin
            ist_q <= ist_q | ev;
         end
      end
   end

   // Interrupt output, registered
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |(ist_q & imask_q);
      end
   end

   // Read data registered at the address phase so it stands in the data phase
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (clk_en && hready) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         unique case (haddr)
            `SB_OFF_CTRL:     hrdata <= ctrl_q;
            `SB_OFF_STATUS:   hrdata <= status_w;
            `SB_OFF_IRQ_STAT: hrdata <= {26'h0000000, ist_q};
            `SB_OFF_IRQ_MASK: hrdata <= {26'h0000000, imask_q};
            `SB_OFF_LOCK:     hrdata <= {31'h00000000, ~lock_n_out};
            default:          hrdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> verilog/sideband_params.svh
/*
 * Constants for the processor sideband control block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes it is included by bare name from the design and bench files.
 */
`ifndef SIDEBAND_PARAMS_SVH
`define SIDEBAND_PARAMS_SVH

// Register byte offsets on the AHB-Lite slave
`define SB_OFF_CTRL      8'h00
`define SB_OFF_STATUS    8'h04
`define SB_OFF_IRQ_STAT  8'h08
`define SB_OFF_IRQ_MASK  8'h0C
`define SB_OFF_LOCK      8'h10

// Control register fields
`define SB_CTRL_LIC_EN   0
`define SB_CTRL_TT_EN    1
`define SB_CTRL_HOT      2
`define SB_CTRL_PROBE_RDY 3
`define SB_CTRL_RST      32'h0000_0003

// Status register fields
`define SB_ST_INIT       0
`define SB_ST_MIRQ       1
`define SB_ST_NMI        2
`define SB_ST_LOCAL0     3
`define SB_ST_LOCAL1     4
`define SB_ST_TT         5
`define SB_ST_EXT_HOT    6
`define SB_ST_PROBE      7
`define SB_ST_BIST       8
`define SB_ST_LOCK       9
`define SB_ST_BREAK      10
`define SB_ST_SNOOP      11

// Event bits in the sticky interrupt status
`define SB_EV_INIT       0
`define SB_EV_NMI        1
`define SB_EV_MIRQ       2
`define SB_EV_HOT        3
`define SB_EV_PROBE      4
`define SB_EV_LOCAL      5
`define SB_EV_W          6

// Reset vector placed in the fetch address after init (arbitrary default)
`define SB_RESET_VECTOR  32'hFFFF_FFF0

// Number of bus clocks within which outputs drop after reset is seen
`define SB_RST_DROP_CLKS 2

`endif

// >>> verilog/sideband_pkg.sv
/*
 * Types for the processor sideband control block.
 * Assumes the params header is on the include path.
 */
package sideband_pkg;
   // Lock sequencer states
   typedef enum logic [1:0] {
      LK_IDLE,
      LK_HOLD,
      LK_DONE
   } lock_state_t;
endpackage

// >>> verilog/sync2.sv
/*
 * Two-flop synchroniser for a group of asynchronous levels.
 * Assumes inputs come from pins outside the core_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;   // First stage, read only by second stage

   // No reset: a strap level held through reset must reach the core on the
   // first edge after release; reset lasts longer than the two stages fill
   always_ff @(posedge core_clk) begin
      if (clk_en) begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire
